/* hw/lom_pkg.sv */
// Shared constants, types and timing for the link OAM control and multiplexer block.
package lom_pkg;

  // ****************************************************************
  // Timing
  // ****************************************************************
  localparam int unsigned CLK_MHZ = 250;
  localparam int unsigned PDU_TIMER_US = 1000000;
  localparam int unsigned PDU_TIMER_TOL_PCT = 10;
  localparam int unsigned PDU_TIMER_CYCLES = PDU_TIMER_US * CLK_MHZ;
  localparam int unsigned TIMER_W = 28;

  // ****************************************************************
  // Budget and widths
  // ****************************************************************
  localparam int unsigned BUDGET_W = 4;
  localparam logic [BUDGET_W-1:0] BUDGET_MAX = 4'ha;
  localparam logic [BUDGET_W-1:0] BUDGET_ZERO = 4'h0;
  localparam logic [BUDGET_W-1:0] BUDGET_ONE = 4'h1;
  localparam int unsigned FRAME_W = 32;
  localparam int unsigned BUF_DEPTH = 2;

  // ****************************************************************
  // Flags field positions and codes
  // ****************************************************************
  localparam int unsigned FLAG_LINK_FAULT = 0;
  localparam int unsigned FLAG_DYING_GASP = 1;
  localparam int unsigned FLAG_CRIT_EVENT = 2;
  localparam int unsigned FLAG_LOC_EVAL = 3;
  localparam int unsigned FLAG_LOC_STABLE = 4;
  localparam int unsigned FLAG_REM_EVAL = 5;
  localparam int unsigned FLAG_REM_STABLE = 6;
  localparam logic [7:0] CODE_INFO = 8'h00;
  localparam logic [15:0] FLAGS_NONE = 16'h0000;
  localparam logic [2:0] CRIT_NONE = 3'h0;

  // ****************************************************************
  // Types
  // ****************************************************************
  typedef enum logic [1:0] {
    PDU_FAULT_ONLY = 2'h0,
    PDU_RX_ONLY = 2'h1,
    PDU_INFO_ONLY = 2'h2,
    PDU_ANY = 2'h3
  } lom_permit_t;

  typedef enum logic [1:0] {
    TLV_NONE = 2'h0,
    TLV_LOCAL = 2'h1,
    TLV_LOCAL_REMOTE = 2'h2,
    TLV_CLIENT = 2'h3
  } lom_tlv_t;

  typedef enum logic [1:0] {
    SRC_PDU = 2'h0,
    SRC_CLIENT = 2'h1,
    SRC_LOOPBACK = 2'h2,
    SRC_IDLE = 2'h3
  } lom_src_t;

  typedef struct packed {
    logic [7:0] code;
    logic [15:0] flags;
    logic hasLocalTlv;
  } lom_rxpdu_t;

  typedef struct packed {
    lom_src_t src;
    lom_tlv_t tlv;
    logic [7:0] code;
    logic [15:0] flags;
    logic [FRAME_W-1:0] data;
  } lom_txword_t;

  localparam int unsigned TXWORD_W = $bits(lom_txword_t);

endpackage

/* hw/lom_pdu_timer.sv */
// Restartable down-counter that flags the end of one transmit second.
`timescale 1ns/1ps
module lom_pdu_timer #(
  parameter int unsigned CYCLES = lom_pkg::PDU_TIMER_CYCLES
) (
  input wire logic clk_sys,
  input wire logic rst_n,
  input wire logic start,
  output logic expired
);
  import lom_pkg::*;

  localparam logic [TIMER_W-1:0] LOAD = TIMER_W'(CYCLES - 1);
  localparam logic [TIMER_W-1:0] ONE = TIMER_W'(1);
  logic [TIMER_W-1:0] count_reg;
  logic expired_reg;
  wire atZero = (count_reg == '0);

  // The count stops at zero so that a late restart still sees the expiry.
  always_ff @(posedge clk_sys or negedge rst_n)
  begin
    if (!rst_n)
    begin
      count_reg <= '0;
      expired_reg <= 1'b0;
    end
    else if (start)
    begin
      count_reg <= LOAD;
      expired_reg <= 1'b0;
    end
    else
    begin
      count_reg <= atZero ? count_reg : count_reg - ONE;
      expired_reg <= atZero;
    end
  end

  assign expired = expired_reg;
endmodule // lom_pdu_timer

/* hw/lom_tx_buf.sv */
// Small shift-style FIFO between the transmit multiplexer and the MAC.
`timescale 1ns/1ps
module lom_tx_buf #(
  parameter int unsigned WIDTH = lom_pkg::TXWORD_W,
  parameter int unsigned DEPTH = lom_pkg::BUF_DEPTH
) (
  input wire logic clk_sys,
  input wire logic rst_n,
  input wire logic inValid,
  output logic inReady,
  input wire logic [WIDTH-1:0] inData,
  output logic outValid,
  input wire logic outReady,
  output logic [WIDTH-1:0] outData
);
  localparam int unsigned CNT_W = $clog2(DEPTH + 1);
  localparam logic [CNT_W-1:0] CNT_ONE = CNT_W'(1);
  localparam logic [CNT_W-1:0] CNT_FULL = CNT_W'(DEPTH);

  logic [WIDTH-1:0] mem_reg [DEPTH];
  logic [CNT_W-1:0] count_reg;
  logic [CNT_W-1:0] count_next;
  logic ready_reg;
  logic valid_reg;
  wire push = inValid && ready_reg;
  wire pop = valid_reg && outReady;
  assign count_next = count_reg + (push ? CNT_ONE : '0) - (pop ? CNT_ONE : '0);

  // The head always sits in entry zero so the output is a plain flop.
  always_ff @(posedge clk_sys or negedge rst_n)
  begin
    if (!rst_n)
    begin
      for (int i = 0; i < DEPTH; i++)
        mem_reg[i] <= '0;
      count_reg <= '0;
      ready_reg <= 1'b1;
      valid_reg <= 1'b0;
    end
    else
    begin
      for (int i = 0; i < DEPTH; i++)
      begin
        if (push && (CNT_W'(i) == (pop ? count_reg - CNT_ONE : count_reg)))
          mem_reg[i] <= inData;
        else if (pop && (i + 1 < DEPTH))
          mem_reg[i] <= mem_reg[(i + 1) % DEPTH];
      end
      count_reg <= count_next;
      ready_reg <= (count_next != CNT_FULL);
      valid_reg <= (count_next != '0);
    end
  end

  assign inReady = ready_reg;
  assign outValid = valid_reg;
  assign outData = mem_reg[0];
endmodule // lom_tx_buf

/* hw/lom_control_mux.sv */
// Discovery, transmit scheduler, receive filter and transmit multiplexer of the link OAM sublayer.
// Functional notes
// - Active mode at link up sends Information PDUs with only local TLV.
// - Passive mode stays silent until the peer's local TLV arrives.
// - Peer local TLV seen: send local and remote TLVs.
// - Local client unsatisfied: fall back to local-plus-remote sending.
// - Client accepts settings: local-satisfied state; return there on remote unsatisfied.
// - Remote satisfied indication enters the fully operational state.
// - Local flags: 01 at start, 00 unsatisfied, 10 satisfied.
// - Unrestricted mode only when local and remote both show stable, not evaluating.
// - Reset state starts one-second timer, reloads budget with ten.
// - Timer expiry after a sent PDU returns to reset.
// - Expiry with nothing sent sends Information PDU; fault mode uses fault flag.
// - Receive-only mode: expiry just restarts the timer.
// - Valid request is sent; budget drops only for non-critical PDUs.
// - Valid: client PDU in Info or unrestricted with budget, or critical in unrestricted.
// - Emit one request, then reset if expired, else wait.
// - Generated PDUs obey the permitted-PDU setting.
// - Unrestricted: critical request sets flag bits; client PDU sent as given.
// - Before discovery completes only Information PDUs reach the client.
// - Unrestricted mode delivers every received PDU to the client.
// - Multiplexer starts waiting and gives OAM PDUs priority over frames.
// - Client frames need forward action; frames need bidirectional or good link.
// - One-second timer holds within ten percent of nominal.
`timescale 1ns/1ps
module lom_control_mux #(
  parameter int unsigned PDU_TIMER_CYC = lom_pkg::PDU_TIMER_CYCLES,
  parameter int unsigned DEPTH = lom_pkg::BUF_DEPTH
) (
  input wire logic clk_sys,
  input wire logic rst_n,
  input wire logic linkGood,
  input wire logic modeActive,
  input wire logic localSatisfied,
  input wire logic unidirectional,
  input wire logic muxForward,
  input wire logic rxPduValid,
  input wire lom_pkg::lom_rxpdu_t rxPdu,
  input wire logic clientPduReq,
  input wire logic [7:0] clientPduCode,
  input wire logic [lom_pkg::FRAME_W-1:0] clientPduData,
  input wire logic [2:0] controlSendRequest,
  input wire logic clientFrameRequest,
  input wire logic [lom_pkg::FRAME_W-1:0] clientFrameData,
  input wire logic loopbackSendRequest,
  input wire logic [lom_pkg::FRAME_W-1:0] loopbackData,
  input wire logic macTxReady,
  output logic macTxValid,
  output lom_pkg::lom_txword_t macTxWord,
  output logic controlReceiveIndication,
  output lom_pkg::lom_rxpdu_t rxIndPdu,
  output logic clientPduAck,
  output logic controlAck,
  output logic clientFrameAck,
  output logic loopbackAck,
  output logic frameDropped,
  output lom_pkg::lom_permit_t localPdu,
  output logic [1:0] localStatusFlags,
  output logic discoveryDone
);
  import lom_pkg::*;

  // ****************************************************************
  // Discovery
  // ****************************************************************
  typedef enum logic [5:0] {
    D_FAULT = 6'h01, D_ACTIVE = 6'h02, D_PASSIVE = 6'h04,
    D_LOCREM = 6'h08, D_LOCREM_OK = 6'h10, D_ANY = 6'h20
  } lom_disc_t;

  lom_disc_t disc_reg;
  lom_disc_t disc_next;
  lom_permit_t permit_reg;
  lom_permit_t permit_next;
  logic remStable_reg;
  logic remEval_reg;
  logic locStable_reg;
  logic locEval_reg;
  wire rxInfo = rxPduValid && (rxPdu.code == CODE_INFO);
  wire [1:0] rxLocBits = {rxPdu.flags[FLAG_LOC_STABLE], rxPdu.flags[FLAG_LOC_EVAL]};
  wire remoteOk = remStable_reg && !remEval_reg;
  wire locStable_next = (disc_next == D_LOCREM_OK) || (disc_next == D_ANY);
  wire locEval_next = (disc_next == D_FAULT) || (disc_next == D_ACTIVE) || (disc_next == D_PASSIVE);

  always_comb
  begin
    disc_next = disc_reg;
    unique case (disc_reg)
      D_FAULT: if (linkGood) disc_next = modeActive ? D_ACTIVE : D_PASSIVE;
      D_ACTIVE, D_PASSIVE: if (rxInfo && rxPdu.hasLocalTlv) disc_next = D_LOCREM;
      D_LOCREM: if (localSatisfied) disc_next = D_LOCREM_OK;
      D_LOCREM_OK: if (!localSatisfied) disc_next = D_LOCREM;
                   else if (remoteOk) disc_next = D_ANY;
      D_ANY: if (!localSatisfied) disc_next = D_LOCREM;
             else if (!remoteOk) disc_next = D_LOCREM_OK;
    endcase
    if (!linkGood)
      disc_next = D_FAULT;
  end

  // The permitted setting follows the state; unrestricted needs all four bits agreeing.
  always_comb
  begin
    unique case (disc_next)
      D_FAULT: permit_next = linkGood ? PDU_RX_ONLY : PDU_FAULT_ONLY;
      D_PASSIVE: permit_next = PDU_RX_ONLY;
      D_ANY: permit_next = (locStable_next && !locEval_next && remoteOk) ? PDU_ANY : PDU_INFO_ONLY;
      default: permit_next = PDU_INFO_ONLY;
    endcase
  end

  always_ff @(posedge clk_sys or negedge rst_n)
  begin
    if (!rst_n)
    begin
      disc_reg <= D_FAULT;
      permit_reg <= PDU_FAULT_ONLY;
      remStable_reg <= 1'b0;
      remEval_reg <= 1'b0;
      locStable_reg <= 1'b0;
      locEval_reg <= 1'b1;
      discoveryDone <= 1'b0;
    end
    else
    begin
      disc_reg <= disc_next;
      permit_reg <= permit_next;
      discoveryDone <= (permit_next == PDU_ANY);
      locStable_reg <= locStable_next;
      locEval_reg <= locEval_next;
      // A received code of 3 is reserved and keeps the last value.
      if (disc_next == D_FAULT)
      begin
        remStable_reg <= 1'b0;
        remEval_reg <= 1'b0;
      end
      else if (rxInfo && (rxLocBits != 2'h3))
      begin
        remStable_reg <= rxLocBits[1];
        remEval_reg <= rxLocBits[0];
      end
    end
  end

  // ****************************************************************
  // Transmit scheduler
  // ****************************************************************
  typedef enum logic [3:0] {T_RESET = 4'h1, T_WAIT = 4'h2, T_EMIT = 4'h4, T_DEC = 4'h8} lom_tx_t;

  lom_tx_t tx_reg;
  lom_tx_t tx_next;
  logic [BUDGET_W-1:0] budget_reg;
  logic sent_reg;
  logic pend_reg;
  logic pendNormal_reg;
  lom_txword_t pend_word_reg;
  logic timerExpired;
  wire canInfo = (permit_reg == PDU_INFO_ONLY) || (permit_reg == PDU_ANY);
  wire clientLegal = (permit_reg == PDU_ANY) || (clientPduCode == CODE_INFO);
  wire normalOk = clientPduReq && canInfo && clientLegal && (budget_reg != BUDGET_ZERO);
  wire critOk = (controlSendRequest != CRIT_NONE) && (permit_reg == PDU_ANY);
  wire takeReq = (tx_reg == T_WAIT) && !pend_reg && (critOk || normalOk);
  wire keepAlive = (tx_reg == T_WAIT) && !pend_reg && !takeReq && timerExpired && !sent_reg
                   && (permit_reg != PDU_RX_ONLY);
  wire [15:0] locFlags = (16'(locStable_reg) << FLAG_LOC_STABLE) | (16'(locEval_reg) << FLAG_LOC_EVAL)
                         | (16'(remStable_reg) << FLAG_REM_STABLE) | (16'(remEval_reg) << FLAG_REM_EVAL);
  wire [15:0] critFlags = 16'(controlSendRequest) << FLAG_LINK_FAULT;
  wire lom_tlv_t infoTlv = (disc_reg == D_ACTIVE) ? TLV_LOCAL : TLV_LOCAL_REMOTE;
  lom_txword_t genWord;

  always_comb
  begin
    genWord = '{src: SRC_PDU, tlv: infoTlv, code: CODE_INFO, flags: locFlags, data: '0};
    if (critOk)
      genWord.flags = locFlags | critFlags;
    else if (normalOk)
    begin
      genWord.tlv = TLV_CLIENT;
      genWord.code = clientPduCode;
      genWord.data = clientPduData;
    end
    else if (permit_reg == PDU_FAULT_ONLY)
    begin
      genWord.tlv = TLV_NONE;
      genWord.flags = locFlags | (16'h0001 << FLAG_LINK_FAULT);
    end
  end

  always_comb
  begin
    tx_next = tx_reg;
    unique case (tx_reg)
      T_RESET: tx_next = T_WAIT;
      T_WAIT: if (takeReq || keepAlive) tx_next = T_EMIT;
              else if (timerExpired && !pend_reg) tx_next = T_RESET;
      T_EMIT: if (pendNormal_reg) tx_next = T_DEC;
              else tx_next = timerExpired ? T_RESET : T_WAIT;
      T_DEC: tx_next = timerExpired ? T_RESET : T_WAIT;
    endcase
  end

  lom_pdu_timer #(.CYCLES(PDU_TIMER_CYC)) u_timer (
    .clk_sys(clk_sys),
    .rst_n(rst_n),
    .start(tx_reg == T_RESET),
    .expired(timerExpired)
  );

  // ****************************************************************
  // Transmit multiplexer and output buffer
  // ****************************************************************
  typedef enum logic [2:0] {M_WAIT = 3'h1, M_LINK_CHECK = 3'h2, M_TX_FRAME = 3'h4} lom_mux_t;

  lom_mux_t mux_reg;
  lom_src_t src_reg;
  lom_txword_t frame_reg;
  logic bufReady;
  wire pduPush = (mux_reg == M_WAIT) && pend_reg && bufReady;
  wire clientWants = clientFrameRequest && muxForward && !clientFrameAck;
  wire loopWants = loopbackSendRequest && !loopbackAck;
  wire frameStart = (mux_reg == M_WAIT) && !pend_reg && (clientWants || loopWants);
  wire linkAllows = !unidirectional || linkGood;
  wire framePush = (mux_reg == M_TX_FRAME) && bufReady;
  wire frameDone = framePush || ((mux_reg == M_LINK_CHECK) && !linkAllows);
  wire bufValid = pduPush || framePush;
  wire lom_txword_t bufIn = pduPush ? pend_word_reg : frame_reg;

  lom_tx_buf #(.WIDTH(TXWORD_W), .DEPTH(DEPTH)) u_buf (
    .clk_sys(clk_sys),
    .rst_n(rst_n),
    .inValid(bufValid),
    .inReady(bufReady),
    .inData(bufIn),
    .outValid(macTxValid),
    .outReady(macTxReady),
    .outData(macTxWord)
  );

  always_ff @(posedge clk_sys or negedge rst_n)
  begin
    if (!rst_n)
    begin
      tx_reg <= T_RESET;
      budget_reg <= BUDGET_MAX;
      sent_reg <= 1'b0;
      pend_reg <= 1'b0;
      pendNormal_reg <= 1'b0;
      pend_word_reg <= '0;
      clientPduAck <= 1'b0;
      controlAck <= 1'b0;
    end
    else
    begin
      tx_reg <= tx_next;
      if (tx_reg == T_RESET)
        budget_reg <= BUDGET_MAX;
      else if (tx_reg == T_DEC)
        budget_reg <= budget_reg - BUDGET_ONE;
      sent_reg <= (tx_reg == T_RESET) ? 1'b0 : (sent_reg || tx_reg == T_EMIT);
      if (takeReq || keepAlive)
      begin
        pend_reg <= 1'b1;
        pend_word_reg <= genWord;
        pendNormal_reg <= takeReq && !critOk;
      end
      else if (pduPush)
        pend_reg <= 1'b0;
      clientPduAck <= takeReq && !critOk;
      controlAck <= takeReq && critOk;
    end
  end

  always_ff @(posedge clk_sys or negedge rst_n)
  begin
    if (!rst_n)
    begin
      mux_reg <= M_WAIT;
      src_reg <= SRC_IDLE;
      frame_reg <= '0;
      clientFrameAck <= 1'b0;
      loopbackAck <= 1'b0;
      frameDropped <= 1'b0;
    end
    else
    begin
      unique case (mux_reg)
        M_WAIT: if (frameStart) mux_reg <= M_LINK_CHECK;
        M_LINK_CHECK: mux_reg <= linkAllows ? M_TX_FRAME : M_WAIT;
        M_TX_FRAME: if (bufReady) mux_reg <= M_WAIT;
      endcase
      if (frameStart)
      begin
        src_reg <= clientWants ? SRC_CLIENT : SRC_LOOPBACK;
        frame_reg <= '{src: clientWants ? SRC_CLIENT : SRC_LOOPBACK, tlv: TLV_NONE, code: CODE_INFO,
                       flags: FLAGS_NONE, data: clientWants ? clientFrameData : loopbackData};
      end
      clientFrameAck <= frameDone && (src_reg == SRC_CLIENT);
      loopbackAck <= frameDone && (src_reg == SRC_LOOPBACK);
      frameDropped <= (mux_reg == M_LINK_CHECK) && !linkAllows;
    end
  end

  // ****************************************************************
  // Receive filter and status
  // ****************************************************************
  always_ff @(posedge clk_sys or negedge rst_n)
  begin
    if (!rst_n)
    begin
      controlReceiveIndication <= 1'b0;
      rxIndPdu <= '0;
    end
    else
    begin
      controlReceiveIndication <= rxPduValid && (rxInfo || permit_reg == PDU_ANY);
      if (rxPduValid)
        rxIndPdu <= rxPdu;
    end
  end

  assign localPdu = permit_reg;
  assign localStatusFlags = {locStable_reg, locEval_reg};

  // ****************************************************************
  // Checks
  // ****************************************************************
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!rst_n);

  AST_LINK_DOWN_FAULT: assert property (!linkGood |=> disc_reg == D_FAULT && permit_reg != PDU_ANY)
    else $error("link down did not force discovery into fault");
  AST_PASSIVE_SILENT: assert property (disc_reg == D_PASSIVE |-> permit_reg == PDU_RX_ONLY && !(takeReq || keepAlive))
    else $error("passive wait generated a pdu");
  AST_ANY_NEEDS_BOTH: assert property (permit_reg == PDU_ANY |-> locStable_reg && !locEval_reg && $past(remoteOk))
    else $error("unrestricted mode without both sides satisfied");
  AST_BUDGET_RELOAD: assert property (tx_reg == T_RESET |=> budget_reg == BUDGET_MAX && tx_reg == T_WAIT)
    else $error("budget not reloaded to ten");
  AST_BUDGET_DEC: assert property (tx_reg == T_EMIT && pendNormal_reg |=> tx_reg == T_DEC ##1 budget_reg == $past(budget_reg, 2) - BUDGET_ONE)
    else $error("normal pdu did not consume budget");
  AST_RXONLY_QUIET: assert property ($rose(pend_reg) |-> $past(permit_reg) != PDU_RX_ONLY)
    else $error("pdu generated in receive-only mode");
  AST_FAULT_WORD: assert property (keepAlive && permit_reg == PDU_FAULT_ONLY |=> pend_word_reg.tlv == TLV_NONE && pend_word_reg.flags[FLAG_LINK_FAULT])
    else $error("fault keepalive lacks fault flag or carries tlvs");
  AST_RX_FILTER: assert property (controlReceiveIndication |-> $past(permit_reg) == PDU_ANY || $past(rxPdu.code) == CODE_INFO)
    else $error("non-information pdu delivered before discovery completed");
  AST_PDU_PRIORITY: assert property (mux_reg == M_WAIT && pend_reg |-> !frameStart and (bufReady |=> !pend_reg))
    else $error("frame took the multiplexer ahead of a pending pdu");
  AST_DROP_UNIDIR: assert property (mux_reg == M_LINK_CHECK && !linkAllows |=> mux_reg == M_WAIT && frameDropped)
    else $error("frame sent on a failed unidirectional link");

  COV_REACH_ANY: cover property (disc_reg == D_LOCREM_OK ##1 disc_reg == D_ANY);
  COV_KEEPALIVE: cover property (keepAlive ##1 tx_reg == T_EMIT);
  COV_FRAME_DROP: cover property (frameDropped);
  COV_BUF_FULL: cover property (!bufReady && macTxValid && !macTxReady);
endmodule // lom_control_mux

/* sim/lom_mac_peer.sv */
// MAC-side partner model: takes words with optional stalls and records them.
`timescale 1ns/1ps
module lom_mac_peer (
  input wire logic clk_sys,
  input wire logic rst_n,
  input wire logic stallEn,
  input wire logic macTxValid,
  input wire lom_pkg::lom_txword_t macTxWord,
  output logic macTxReady,
  output int wordCount
);
  import lom_pkg::*;
  logic [1:0] phase_reg;
  lom_txword_t words [0:31];
  // A stalling MAC is ready one cycle in four, so the buffer must hold words.
  assign macTxReady = !stallEn || (phase_reg == 2'h3);
  always_ff @(posedge clk_sys or negedge rst_n)
  begin
    if (!rst_n)
    begin
      phase_reg <= 2'h0;
      wordCount <= 0;
    end
    else
    begin
      phase_reg <= phase_reg + 2'h1;
      if (macTxValid && macTxReady)
      begin
        words[wordCount[4:0]] <= macTxWord;
        wordCount <= wordCount + 1;
      end
    end
  end
endmodule // lom_mac_peer

/* sim/test_link_oam_control_mux.sv */
// Self-checking bench for the link OAM control and multiplexer block.
`timescale 1ns/1ps
module test_link_oam_control_mux;
  import lom_pkg::*;
  logic clk_sys = 0, rst_n = 0, linkGood = 1, modeActive = 0, localSatisfied = 0;
  logic unidirectional = 0, muxForward = 1, rxPduValid = 0, clientPduReq = 0;
  logic clientFrameRequest = 0, loopbackSendRequest = 0, macTxReady, stallEn = 0;
  logic macTxValid, controlReceiveIndication, clientPduAck, controlAck;
  logic clientFrameAck, loopbackAck, frameDropped, discoveryDone;
  logic [7:0] clientPduCode = 8'h00;
  logic [2:0] controlSendRequest = 3'h0;
  logic [31:0] clientFrameData = 32'h1234abcd, loopbackData = 32'h5a5a0001;
  logic [1:0] localStatusFlags;
  lom_rxpdu_t rxPdu = '0, rxIndPdu;
  lom_txword_t macTxWord;
  lom_permit_t localPdu;
  int failures = 0, n_checks = 0, indCount = 0, base, cnt;
  bit ok;

  always #2 clk_sys = ~clk_sys;
  always @(posedge clk_sys) if (controlReceiveIndication === 1'b1) indCount++;

  lom_control_mux #(.PDU_TIMER_CYC(300)) DUT (.clk_sys(clk_sys), .rst_n(rst_n), .linkGood(linkGood),
    .modeActive(modeActive), .localSatisfied(localSatisfied), .unidirectional(unidirectional),
    .muxForward(muxForward), .rxPduValid(rxPduValid), .rxPdu(rxPdu), .clientPduReq(clientPduReq),
    .clientPduCode(clientPduCode), .clientPduData(clientFrameData), .controlSendRequest(controlSendRequest),
    .clientFrameRequest(clientFrameRequest), .clientFrameData(clientFrameData),
    .loopbackSendRequest(loopbackSendRequest), .loopbackData(loopbackData), .macTxReady(macTxReady),
    .macTxValid(macTxValid), .macTxWord(macTxWord), .controlReceiveIndication(controlReceiveIndication),
    .rxIndPdu(rxIndPdu), .clientPduAck(clientPduAck), .controlAck(controlAck),
    .clientFrameAck(clientFrameAck), .loopbackAck(loopbackAck), .frameDropped(frameDropped),
    .localPdu(localPdu), .localStatusFlags(localStatusFlags), .discoveryDone(discoveryDone));
  lom_mac_peer PEER (.clk_sys(clk_sys), .rst_n(rst_n), .stallEn(stallEn), .macTxValid(macTxValid),
    .macTxWord(macTxWord), .macTxReady(macTxReady), .wordCount());

  // ****************************************************************
  // Access tasks
  // ****************************************************************
  task automatic tick(input int n);
    repeat (n) @(posedge clk_sys);
  endtask

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    n_checks++;
    if (seen !== exp)
    begin
      failures++;
      $display("ERROR %0t: got %h expected %h", $time, seen, exp);
    end
  endtask

  // Waits for a one-cycle pulse as seen at a rising edge.
  task automatic wait_hi(ref logic s, input int lim, output bit hit);
    hit = 0;
    for (int i = 0; i < lim && !hit; i++)
    begin
      @(posedge clk_sys);
      hit = (s === 1'b1);
    end
  endtask

  task automatic wait_words(input int n, input int lim);
    for (int i = 0; i < lim && PEER.wordCount < n; i++) @(posedge clk_sys);
    check(PEER.wordCount >= n, 1);
  endtask

  task automatic send_rx(input logic [7:0] code, input logic [15:0] flags, input logic tlv);
    rxPduValid <= 1'b1;
    rxPdu <= '{code: code, flags: flags, hasLocalTlv: tlv};
    tick(1);
    rxPduValid <= 1'b0;
    tick(4);
  endtask

  // The request stays up when refused, so a later second can still take it.
  task automatic client_req(input logic [7:0] code, input int lim, output bit hit);
    clientPduReq <= 1'b1;
    clientPduCode <= code;
    wait_hi(clientPduAck, lim, hit);
    if (hit) clientPduReq <= 1'b0;
    if (hit) tick(3);
  endtask

  task automatic stop_test;
    $display("Checks %0d, mismatches %0d", n_checks, failures);
    if (failures == 0 && n_checks > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask

  initial
  begin
    #80000;
    failures++;
    $display("ERROR %0t: watchdog expired", $time);
    stop_test();
  end

  // ****************************************************************
  // Tests
  // ****************************************************************
  initial
  begin
    tick(6);
    rst_n <= 1'b1;
    tick(350);
    check(PEER.wordCount, 0);
    check(localStatusFlags, 2'b01);
    send_rx(8'h01, FLAGS_NONE, 1'b0);
    check(indCount, 0);
    send_rx(CODE_INFO, FLAGS_NONE, 1'b1);
    check(indCount, 1);
    check(localStatusFlags, 2'b00);
    wait_words(1, 400);
    check(PEER.words[0].tlv, TLV_LOCAL_REMOTE);
    check(PEER.words[0].code, CODE_INFO);
    localSatisfied <= 1'b1;
    tick(3);
    check(localStatusFlags, 2'b10);
    send_rx(CODE_INFO, 16'h0010, 1'b1);
    check(localPdu, PDU_ANY);
    check(discoveryDone, 1);
    send_rx(8'hfe, FLAGS_NONE, 1'b0);
    check(rxIndPdu.code, 8'hfe);
    send_rx(CODE_INFO, 16'h0008, 1'b1);
    check(discoveryDone, 0);
    check(localStatusFlags, 2'b10);
    send_rx(CODE_INFO, 16'h0010, 1'b1);
    check(discoveryDone, 1);
    localSatisfied <= 1'b0;
    tick(3);
    check(discoveryDone, 0);
    check(localStatusFlags, 2'b00);
    localSatisfied <= 1'b1;
    tick(4);
    check(localPdu, PDU_ANY);
    $display("Discovery test done");
    base = PEER.wordCount;
    controlSendRequest <= 3'b100;
    wait_hi(controlAck, 20, ok);
    controlSendRequest <= 3'h0;
    check(ok, 1);
    wait_words(base + 1, 50);
    check(PEER.words[base].flags[FLAG_CRIT_EVENT], 1);
    stallEn <= 1'b1;
    base = PEER.wordCount;
    clientPduReq <= 1'b1;
    clientPduCode <= 8'h05;
    tick(1);
    clientFrameRequest <= 1'b1;
    wait_hi(clientPduAck, 20, ok);
    clientPduReq <= 1'b0;
    check(ok, 1);
    wait_hi(clientFrameAck, 60, ok);
    clientFrameRequest <= 1'b0;
    loopbackSendRequest <= 1'b1;
    check(ok, 1);
    wait_hi(loopbackAck, 60, ok);
    loopbackSendRequest <= 1'b0;
    check(ok, 1);
    wait_words(base + 3, 100);
    check(PEER.words[base].src, SRC_PDU);
    check(PEER.words[base].code, 8'h05);
    check(PEER.words[base].data, 32'h1234abcd);
    check(PEER.words[base + 1].src, SRC_CLIENT);
    check(PEER.words[base + 1].data, 32'h1234abcd);
    check(PEER.words[base + 2].src, SRC_LOOPBACK);
    stallEn <= 1'b0;
    muxForward <= 1'b0;
    clientFrameRequest <= 1'b1;
    wait_hi(clientFrameAck, 20, ok);
    check(ok, 0);
    clientFrameRequest <= 1'b0;
    muxForward <= 1'b1;
    $display("Transmit and multiplexer test done");
    rst_n <= 1'b0;
    modeActive <= 1'b1;
    tick(2);
    rst_n <= 1'b1;
    tick(3);
    check(localPdu, PDU_INFO_ONLY);
    check(localStatusFlags, 2'b01);
    cnt = 0;
    for (int i = 0; i < 10; i++)
    begin
      client_req(CODE_INFO, 60, ok);
      cnt += ok;
    end
    check(cnt, 10);
    client_req(CODE_INFO, 60, ok);
    check(ok, 0);
    wait_hi(clientPduAck, 300, ok);
    clientPduReq <= 1'b0;
    check(ok, 1);
    tick(5);
    base = PEER.wordCount;
    wait_words(base + 1, 700);
    check(PEER.words[base].tlv, TLV_LOCAL);
    $display("Budget test done");
    linkGood <= 1'b0;
    unidirectional <= 1'b1;
    tick(3);
    check(localPdu, PDU_FAULT_ONLY);
    loopbackSendRequest <= 1'b1;
    wait_hi(frameDropped, 10, ok);
    loopbackSendRequest <= 1'b0;
    check(ok, 1);
    base = PEER.wordCount;
    wait_words(base + 1, 700);
    check(PEER.words[base].tlv, TLV_NONE);
    check(PEER.words[base].flags[FLAG_LINK_FAULT], 1);
    $display("Fault test done");
    stop_test();
  end
endmodule // test_link_oam_control_mux
